// ===== verilog/sar_conversion_sequencer.sv
// Purpose: Control logic of an 18-bit successive-approximation converter
// Assumes: Comparator and range detectors are level inputs from the analog core
// Notes: Conversion is timed from ref_clk only; serial clock is read back only
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_sequencer
  import sar_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic convert_start,
  input wire logic serial_in_or_select,
  input wire logic sclk,
  input wire sar_seq_pkg::comp_in_t comp_in,
  output sar_seq_pkg::switch_ctl_t switch_ctl,
  output logic serial_result_out,
  output logic serial_result_out_oe_n,
  output logic [17:0] result,
  output logic result_valid,
  output logic chain_mode,
  output logic busy
);
  import sar_seq_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Comparator bits are levels, so one cycle of skew between them is harmless
  logic [1:0] start_s_r;
  logic [1:0] sel_s_r;
  logic [1:0] sck_s_r;
  logic [2:0] cmp_s1_r;
  logic [2:0] cmp_s2_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      start_s_r <= '0;
      sel_s_r <= '0;
      sck_s_r <= '0;
      cmp_s1_r <= '0;
      cmp_s2_r <= '0;
    end else begin
      start_s_r <= {start_s_r[0], convert_start};
      sel_s_r <= {sel_s_r[0], serial_in_or_select};
      sck_s_r <= {sck_s_r[0], sclk};
      cmp_s1_r <= comp_in;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  logic start_q;
  logic sel_q;
  logic sck_q;
  comp_in_t cmp_q;
  assign start_q = start_s_r[1];
  assign sel_q = sel_s_r[1];
  assign sck_q = sck_s_r[1];
  assign cmp_q = comp_in_t'(cmp_s2_r);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t state;
    logic busy;
    logic start_d;
    logic sck_d;
    logic chain;
    logic [7:0] cnt;
    logic [4:0] idx;
    logic [17:0] trial;
    logic over;
    logic under;
    switch_ctl_t sw;
    logic [17:0] res;
    logic res_valid;
    logic push;
    logic ser_bit;
    logic ser_oe_n;
  } seq_st_t;

  seq_st_t st_r;
  seq_st_t st_nxt;

  logic start_rise;
  logic start_taken;
  logic sclk_fall;
  logic select_enable;
  logic chain_enable;
  logic selected;
  logic ser_enable;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [17:0] fifo_out_data;
  logic shf_load;
  logic shf_bit;
  logic shf_drive;

  // ----------------------------------------------------------------
  // Start detection and readback select
  // ----------------------------------------------------------------
  assign start_rise = start_q && !st_r.start_d;
  // Start is refused while the FIFO is full so no result is dropped
  assign start_taken = start_rise && fifo_in_ready;
  // Serial clock is only watched for readback, never for conversion steps
  assign sclk_fall = st_r.sck_d && !sck_q;
  // Select mode: a low select pin or a low convert_start enables the output
  assign select_enable = !(sel_q && start_q);
  // Chain mode: results are read while convert_start stays high
  assign chain_enable = start_q;
  assign selected = (st_r.state == ST_ACQUIRE) &&
                    (st_r.chain ? chain_enable : select_enable);
  // Output lets go in the cycle selection ends, not a cycle after the shifter
  assign ser_enable = shf_drive && selected;
  // Next result leaves the FIFO when the previous readback is idle
  assign shf_load = fifo_out_valid && !selected && !shf_drive;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.start_d = start_q;
    st_nxt.sck_d = sck_q;
    st_nxt.push = 1'b0;
    st_nxt.ser_bit = shf_bit;
    st_nxt.ser_oe_n = !ser_enable;
    case (st_r.state)
      ST_ACQUIRE: begin
        // Arrays sample the inputs, core idles powered down
        st_nxt.sw.pos_array_ground_switch = 1'b1;
        st_nxt.sw.neg_array_ground_switch = 1'b1;
        st_nxt.sw.arrays_to_inputs = 1'b1;
        st_nxt.sw.arrays_to_ground = 1'b0;
        st_nxt.sw.bit_to_ref = CODE_ZERO;
        st_nxt.sw.power_down = 1'b1;
        if (start_taken) begin
          st_nxt.chain = !sel_q;
          st_nxt.state = ST_OPEN_SW;
          st_nxt.sw.power_down = 1'b0;
          st_nxt.sw.pos_array_ground_switch = 1'b0;
          st_nxt.sw.neg_array_ground_switch = 1'b0;
          st_nxt.cnt = SETTLE_CYCLES_M1;
          st_nxt.res_valid = 1'b0;
        end
      end
      ST_OPEN_SW: begin
        if (st_r.cnt == CNT_ZERO) begin
          // Inputs let go only after the ground switches have opened
          st_nxt.sw.arrays_to_inputs = 1'b0;
          st_nxt.sw.arrays_to_ground = 1'b1;
          st_nxt.cnt = SETTLE_CYCLES_M1;
          st_nxt.state = ST_GROUND;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      ST_GROUND: begin
        if (st_r.cnt == CNT_ZERO) begin
          st_nxt.idx = MSB_IDX;
          st_nxt.trial = SIGN_FLIP;
          st_nxt.sw.bit_to_ref = SIGN_FLIP;
          st_nxt.cnt = BIT_CYCLES_M1;
          // Range flags are caught once, from the held sample, before any trial
          st_nxt.over = cmp_q.over_range;
          st_nxt.under = cmp_q.under_range;
          st_nxt.state = ST_DECIDE;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      ST_DECIDE: begin
        if (st_r.cnt == CNT_ZERO) begin
          // Comparator is two flops late; the bit time leaves room for that
          // Keep the trial bit when the array is still below the held input
          st_nxt.trial[st_r.idx] = cmp_q.comp_high;
          if (st_r.idx == IDX_ZERO) begin
            st_nxt.state = ST_FINISH;
          end else begin
            st_nxt.trial[st_r.idx - 5'h01] = 1'b1;
            st_nxt.idx = st_r.idx - 5'h01;
            st_nxt.cnt = BIT_CYCLES_M1;
          end
          st_nxt.sw.bit_to_ref = st_nxt.trial;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end
      ST_FINISH: begin
        // Offset binary from the array becomes two's complement by a sign flip
        if (st_r.over) begin
          st_nxt.res = CODE_POS_FULL;
        end else if (st_r.under) begin
          st_nxt.res = CODE_NEG_FULL;
        end else begin
          st_nxt.res = st_r.trial ^ SIGN_FLIP;
        end
        st_nxt.res_valid = 1'b1;
        st_nxt.push = 1'b1;
        st_nxt.state = ST_ACQUIRE;
        st_nxt.sw.bit_to_ref = CODE_ZERO;
        st_nxt.sw.arrays_to_ground = 1'b0;
        st_nxt.sw.arrays_to_inputs = 1'b1;
        st_nxt.sw.pos_array_ground_switch = 1'b1;
        st_nxt.sw.neg_array_ground_switch = 1'b1;
        st_nxt.sw.power_down = 1'b1;
      end
      default: begin
        st_nxt.state = ST_ACQUIRE;
      end
    endcase
    // Busy is registered beside the state so the port comes from a flop
    st_nxt.busy = (st_nxt.state != ST_ACQUIRE);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // Reset leaves the arrays sampling, the core powered down, no result
      st_r <= '0;
      st_r.state <= ST_ACQUIRE;
      st_r.busy <= 1'b0;
      st_r.start_d <= 1'b0;
      st_r.sck_d <= 1'b0;
      st_r.chain <= 1'b0;
      st_r.cnt <= CNT_ZERO;
      st_r.idx <= IDX_ZERO;
      st_r.trial <= CODE_ZERO;
      st_r.over <= 1'b0;
      st_r.under <= 1'b0;
      st_r.res <= CODE_ZERO;
      st_r.res_valid <= 1'b0;
      st_r.push <= 1'b0;
      st_r.ser_bit <= 1'b0;
      st_r.sw.bit_to_ref <= CODE_ZERO;
      st_r.sw.pos_array_ground_switch <= 1'b1;
      st_r.sw.neg_array_ground_switch <= 1'b1;
      st_r.sw.arrays_to_inputs <= 1'b1;
      st_r.sw.arrays_to_ground <= 1'b0;
      st_r.sw.power_down <= 1'b1;
      st_r.ser_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Result buffering and readback
  // ----------------------------------------------------------------
  // One result per conversion; full FIFO holds off new starts
  result_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(st_r.push),
    .in_ready(fifo_in_ready),
    .in_data(st_r.res),
    .out_valid(fifo_out_valid),
    .out_ready(shf_load),
    .out_data(fifo_out_data)
  );

  // Chain data comes from the select pin, synchronised like the other pins
  serial_shifter u_shf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .selected(selected),
    .sclk_fall(sclk_fall),
    .chain_in(sel_q),
    .load(shf_load),
    .load_data(fifo_out_data),
    .out_bit(shf_bit),
    .out_drive(shf_drive)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign switch_ctl = st_r.sw;
  assign serial_result_out = st_r.ser_bit;
  assign serial_result_out_oe_n = st_r.ser_oe_n;
  assign result = st_r.res;
  assign result_valid = st_r.res_valid;
  assign chain_mode = st_r.chain;
  assign busy = st_r.busy;
endmodule : sar_conversion_sequencer
`default_nettype wire

// ===== verilog/sar_seq_pkg.sv
// Purpose: Shared constants and carrier types for the SAR conversion sequencer
// Assumes: 125 MHz ref_clk, 18-bit result
// Notes: All timing figures are named here and turned into cycle counts
package sar_seq_pkg;

  localparam int RES_BITS = 18;
  localparam int CLK_MHZ = 125;
  // Conversion clock divider: one bit decision per this many ns, rounded up to ref_clk cycles
  localparam int BIT_TIME_NS = 40;
  localparam int BIT_CYCLES = (BIT_TIME_NS * CLK_MHZ + 999) / 1000;
  // Settle time between opening ground switches and grounding arrays
  localparam int SETTLE_NS = 16;
  localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] BIT_CYCLES_M1 = 8'(BIT_CYCLES - 1);
  localparam logic [7:0] SETTLE_CYCLES_M1 = 8'(SETTLE_CYCLES - 1);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [4:0] MSB_IDX = 5'h11;
  localparam logic [4:0] IDX_ZERO = 5'h00;

  // Result codes
  localparam logic [17:0] CODE_ZERO = 18'h00000;
  localparam logic [17:0] CODE_POS_FULL = 18'h1ffff;
  localparam logic [17:0] CODE_NEG_FULL = 18'h20000;
  localparam logic [17:0] SIGN_FLIP = 18'h20000;

  localparam int FIFO_WIDTH = RES_BITS;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_ACQUIRE = 3'b000,
    ST_OPEN_SW = 3'b001,
    ST_GROUND = 3'b011,
    ST_DECIDE = 3'b010,
    ST_FINISH = 3'b110
  } seq_state_t;

  // Analog switch controls toward the capacitor arrays
  typedef struct packed {
    logic pos_array_ground_switch;
    logic neg_array_ground_switch;
    logic arrays_to_inputs;
    logic arrays_to_ground;
    logic [17:0] bit_to_ref;
    logic power_down;
  } switch_ctl_t;

  // Comparator side inputs
  typedef struct packed {
    logic comp_high;
    logic over_range;
    logic under_range;
  } comp_in_t;

endpackage : sar_seq_pkg

// ===== verilog/result_fifo.sv
// Purpose: Flop-based FIFO holding finished conversion results
// Assumes: Single clock, one push and one pop per cycle at most
// Notes: Full and empty are exact; ready drops when full
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_st_t;

  fifo_st_t st_r;
  fifo_st_t st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid = (st_r.count != '0);
  assign out_data = mem_r[st_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage: one generate entry per word, written by index
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_mem
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          mem_r[g] <= '0;
        end else if (push && (st_r.wr == AW'(g))) begin
          mem_r[g] <= in_data;
        end
      end
    end
  endgenerate
endmodule : result_fifo
`default_nettype wire

// ===== verilog/serial_shifter.sv
// Purpose: Shifts one result out MSB first in step with the host serial clock
// Assumes: Serial clock and select already synchronised to ref_clk
// Notes: MSB appears on select, then one bit per falling serial clock edge
`timescale 1ns/100ps
`default_nettype none
module serial_shifter
  import sar_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic selected,
  input wire logic sclk_fall,
  input wire logic chain_in,
  input wire logic load,
  input wire logic [17:0] load_data,
  output logic out_bit,
  output logic out_drive
);
  typedef struct packed {
    logic [17:0] sh;
    logic [4:0] left;
    logic active;
    logic sel_d;
  } shf_st_t;

  shf_st_t st_r;
  shf_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sel_d = selected;
    if (load) begin
      st_nxt.sh = load_data;
      st_nxt.active = 1'b0;
    end else if (selected && !st_r.sel_d) begin
      st_nxt.active = 1'b1;
      st_nxt.left = MSB_IDX;
    end else if (!selected) begin
      st_nxt.active = 1'b0;
    end else if (st_r.active && sclk_fall) begin
      // Chain input fills from the bottom so cascaded results follow
      st_nxt.sh = {st_r.sh[16:0], chain_in};
      if (st_r.left == IDX_ZERO) begin
        st_nxt.active = 1'b0;
      end else begin
        st_nxt.left = st_r.left - 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_bit = st_r.sh[17];
  assign out_drive = st_r.active;
endmodule : serial_shifter
`default_nettype wire

// ===== tb/sar_seq_props.sv
// Purpose: Port assertions for the conversion sequencer
// Assumes: Two-cycle settle steps and a five-cycle bit time
// Notes: Bound into every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module sar_seq_checker
  import sar_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic convert_start,
  input wire logic serial_in_or_select,
  input wire logic sclk,
  input wire sar_seq_pkg::comp_in_t comp_in,
  input wire sar_seq_pkg::switch_ctl_t switch_ctl,
  input wire logic serial_result_out,
  input wire logic serial_result_out_oe_n,
  input wire logic [17:0] result,
  input wire logic result_valid,
  input wire logic chain_mode,
  input wire logic busy
);
  // ----
  // Helper
  // ----
  logic [7:0] busy_cnt_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) busy_cnt_r <= 8'h00;
    else if (!busy) busy_cnt_r <= 8'h00;
    else busy_cnt_r <= busy_cnt_r + 8'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----
  // Properties
  // ----
  sequence s_acq;
    switch_ctl.pos_array_ground_switch && switch_ctl.neg_array_ground_switch &&
    switch_ctl.arrays_to_inputs && !switch_ctl.arrays_to_ground && switch_ctl.power_down;
  endsequence
  sequence s_opened;
    !switch_ctl.pos_array_ground_switch && !switch_ctl.neg_array_ground_switch &&
    switch_ctl.arrays_to_inputs;
  endsequence
  sequence s_grounded;
    !switch_ctl.arrays_to_inputs && switch_ctl.arrays_to_ground;
  endsequence
  property p_acq;
    !busy && !$past(busy) |-> s_acq;
  endproperty
  property p_open;
    $rose(busy) |-> s_opened [*2] ##1 s_grounded;
  endproperty
  property p_msb;
    $rose(busy) |-> ##4 (switch_ctl.bit_to_ref == 18'h20000);
  endproperty
  property p_len;
    $fell(busy) |-> busy_cnt_r inside {[8'd88:8'd100]};
  endproperty
  property p_valid;
    $fell(busy) |-> ##[0:2] result_valid;
  endproperty
  property p_hold;
    $changed(result) |-> $rose(result_valid);
  endproperty
  property p_cause;
    $rose(busy) |-> $past(convert_start);
  endproperty
  property p_oe;
    busy && $past(busy) |-> serial_result_out_oe_n;
  endproperty
  property p_mode;
    $rose(busy) |-> ##2 (chain_mode == !serial_in_or_select);
  endproperty
  a_acq: assert property (p_acq) else $error("idle switches wrong");
  a_open: assert property (p_open) else $error("switch order wrong");
  a_msb: assert property (p_msb) else $error("first trial not top bit");
  a_len: assert property (p_len) else $error("conversion length wrong");
  a_valid: assert property (p_valid) else $error("no result after finish");
  a_hold: assert property (p_hold) else $error("result changed while held");
  a_cause: assert property (p_cause) else $error("busy without start");
  a_oe: assert property (p_oe) else $error("output driven in conversion");
  a_mode: assert property (p_mode) else $error("mode latch wrong");
endmodule : sar_seq_checker
bind sar_conversion_sequencer sar_seq_checker chk (.ref_clk(ref_clk), .resetn(resetn),
  .convert_start(convert_start), .serial_in_or_select(serial_in_or_select), .sclk(sclk),
  .comp_in(comp_in), .switch_ctl(switch_ctl), .serial_result_out(serial_result_out),
  .serial_result_out_oe_n(serial_result_out_oe_n), .result(result),
  .result_valid(result_valid), .chain_mode(chain_mode), .busy(busy));
`default_nettype wire

// ===== tb/sar_core_model.sv
// Purpose: Behavioural analog core: track-and-hold plus comparator
// Assumes: Input code in two's complement
// Notes: Comparator output is noise until the arrays hold the sample
`timescale 1ns/100ps
`default_nettype none
module sar_core_model
  import sar_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire sar_seq_pkg::switch_ctl_t switch_ctl,
  input wire logic [17:0] code_in,
  input wire logic over_in,
  input wire logic under_in,
  output sar_seq_pkg::comp_in_t comp_in
);
  logic [17:0] held_r;
  logic over_r, under_r, junk_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      held_r <= 18'h00000;
      over_r <= 1'b0;
      under_r <= 1'b0;
      junk_r <= 1'b0;
    end else begin
      junk_r <= !junk_r;
      if (switch_ctl.arrays_to_inputs) begin
        held_r <= code_in ^ SIGN_FLIP;
        over_r <= over_in;
        under_r <= under_in;
      end
    end
  end
  always_comb begin
    comp_in.over_range = over_r;
    comp_in.under_range = under_r;
    comp_in.comp_high = junk_r;
    if (switch_ctl.arrays_to_ground) begin
      comp_in.comp_high = switch_ctl.bit_to_ref <= held_r;
    end
  end
endmodule : sar_core_model
`default_nettype wire

// ===== tb/sar_conversion_sequencer_bench.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Select mode readback with convert low
// Notes: Inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_sequencer_bench;
  import sar_seq_pkg::*;
  logic ref_clk, resetn, convert_start, serial_in_or_select, sclk;
  logic [17:0] code_in, result;
  logic over_in, under_in, ser_out, oe_n, result_valid, chain_mode, busy;
  comp_in_t comp_in;
  switch_ctl_t switch_ctl;
  int mismatches, num_checks;
  sar_conversion_sequencer uut (.ref_clk(ref_clk), .resetn(resetn),
    .convert_start(convert_start), .serial_in_or_select(serial_in_or_select), .sclk(sclk),
    .comp_in(comp_in), .switch_ctl(switch_ctl), .serial_result_out(ser_out),
    .serial_result_out_oe_n(oe_n), .result(result), .result_valid(result_valid),
    .chain_mode(chain_mode), .busy(busy));
  sar_core_model core (.ref_clk(ref_clk), .resetn(resetn), .switch_ctl(switch_ctl),
    .code_in(code_in), .over_in(over_in), .under_in(under_in), .comp_in(comp_in));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----
  // Tasks
  // ----
  task automatic complete_run;
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_busy(input logic level);
    int n;
    n = 0;
    while (busy !== level) begin
      @(negedge ref_clk);
      if (level == 1'b0) sclk = ~sclk;
      n++;
      if (n > 300) begin
        mismatches++;
        $display("wrong value at %0t: busy timeout", $time);
        complete_run();
      end
    end
    sclk = 1'b0;
  endtask : wait_busy
  task automatic do_conv(input logic [17:0] code, input logic ov, input logic un,
                         input logic sel, input logic [17:0] exp);
    convert_start = 1'b0;
    code_in = code;
    over_in = ov;
    under_in = un;
    serial_in_or_select = sel;
    // Spacing keeps starts inside the faster rated rate
    repeat (160) @(negedge ref_clk);
    convert_start = 1'b1;
    wait_busy(1'b1);
    repeat (8) @(negedge ref_clk);
    // Input moves after the hold; a second start edge must be ignored
    code_in = ~code;
    over_in = !ov;
    convert_start = 1'b0;
    @(negedge ref_clk);
    convert_start = 1'b1;
    wait_busy(1'b0);
    repeat (3) @(negedge ref_clk);
    check(result, exp);
    check(18'(result_valid), 18'h1);
    check(18'(chain_mode), 18'(!sel));
    check(18'(switch_ctl.power_down), 18'h1);
    check(18'(switch_ctl.arrays_to_inputs), 18'h1);
  endtask : do_conv
  task automatic read_back(input logic [17:0] exp);
    convert_start = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(18'(oe_n), 18'h0);
    for (int i = 17; i >= 0; i--) begin
      check(18'(ser_out), 18'(exp[i]));
      sclk = 1'b1;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
    check(18'(oe_n), 18'h1);
  endtask : read_back
  task automatic reset_mid;
    convert_start = 1'b0;
    repeat (160) @(negedge ref_clk);
    convert_start = 1'b1;
    wait_busy(1'b1);
    repeat (20) @(negedge ref_clk);
    resetn = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(18'(busy), 18'h0);
    check(result, 18'h00000);
    check(18'(result_valid), 18'h0);
    check(18'(oe_n), 18'h1);
    resetn = 1'b1;
  endtask : reset_mid
  // ----
  // Main sequence
  // ----
  initial begin
    mismatches = 0;
    num_checks = 0;
    resetn = 1'b0;
    convert_start = 1'b0;
    serial_in_or_select = 1'b1;
    sclk = 1'b0;
    code_in = 18'h00000;
    over_in = 1'b0;
    under_in = 1'b0;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    do_conv(18'h00000, 1'b0, 1'b0, 1'b1, 18'h00000);
    do_conv(18'h00001, 1'b0, 1'b0, 1'b1, 18'h00001);
    do_conv(18'h3ffff, 1'b0, 1'b0, 1'b1, 18'h3ffff);
    do_conv(18'h15a5a, 1'b0, 1'b0, 1'b1, 18'h15a5a);
    read_back(18'h15a5a);
    do_conv(18'h00000, 1'b1, 1'b0, 1'b1, 18'h1ffff);
    do_conv(18'h00000, 1'b0, 1'b1, 1'b1, 18'h20000);
    do_conv(18'h2a5a5, 1'b0, 1'b0, 1'b0, 18'h2a5a5);
    reset_mid();
    do_conv(18'h20001, 1'b0, 1'b0, 1'b1, 18'h20001);
    read_back(18'h20001);
    complete_run();
  end
endmodule : sar_conversion_sequencer_bench
`default_nettype wire
